// ### hw/sbt_regs.vh
`ifndef SBT_REGS_VH
`define SBT_REGS_VH

// ==========================================================================
// serial test widths
`define SBT_IR_W        8
`define SBT_BS_W        84
`define SBT_BC_W        21
`define SBT_ID_W        32
`define SBT_IR_STATUS   8'h81

// ==========================================================================
// opcodes, bit 7 gives even parity over the byte
`define SBT_OP_EXTEST   8'h00
`define SBT_OP_INTEST   8'h03
`define SBT_OP_HIGHZ    8'h06
`define SBT_OP_RUNT     8'h09
`define SBT_OP_SCANCT   8'h0A
`define SBT_OP_IDCODE   8'h82
`define SBT_OP_SAMPLE   8'h84
`define SBT_OP_CLAMP    8'h87
`define SBT_OP_SCANCN   8'h88
`define SBT_OP_BYPASS   8'hFF

// ==========================================================================
// boundary chain field positions
`define SBT_BS_CTL      0
`define SBT_BS_AIN      12
`define SBT_BS_AOUT     30
`define SBT_BS_BIN      48
`define SBT_BS_BOUT     66

// ==========================================================================
// boundary control chain fields
`define SBT_BC_OP       0
`define SBT_BC_SIDE     2
`define SBT_BC_MASK     3
`define SBT_BC_RESET    21'h1FFFF8
`define SBT_BCOP_NONE   2'h0
`define SBT_BCOP_PSA    2'h1
`define SBT_BCOP_PSEUDORANDOM_DRIVE   2'h2
`define SBT_BCOP_COUNT  2'h3

`endif

// ### hw/sbt_transceiver.v
`timescale 1ns/1ps
`include "sbt_regs.vh"
// ==========================================================================
// capture stream buffer
module sbt_fifo #(
  parameter W  = 18,
  parameter D  = 8,
  parameter AW = 3
) (
  // clock and reset
  input  wire         ref_clk_i,
  input  wire         resetn_i,
  // fill side
  input  wire         in_valid_i,
  output wire         in_ready_o,
  input  wire [W-1:0] in_data_i,
  // drain side
  output wire         out_valid_o,
  input  wire         out_ready_i,
  output wire [W-1:0] out_data_o
);
  reg  [W-1:0] mem [0:D-1];
  reg  [AW-1:0] wr_ptr;
  reg  [AW-1:0] rd_ptr;
  reg  [AW:0]   count;
  wire          push;
  wire          pop;
  assign in_ready_o  = (count != D[AW:0]);
  assign out_valid_o = (count != {(AW+1){1'b0}});
  assign out_data_o  = mem[rd_ptr];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;
  always @(posedge ref_clk_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end
  always @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count  <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
      end
      if (push & ~pop) begin
        count <= count + 1'b1;
      end else if (pop & ~push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule // sbt_fifo
// ==========================================================================
// scan-testable bus transceiver
module sbt_transceiver #(
  parameter [31:0] ID_CODE  = 32'h0000_5A5B, // arbitrary value
  parameter        LOG_DEPTH = 8
) (
  // clock and reset
  input  wire        ref_clk_i,
  input  wire        resetn_i,
  // A bus pins
  input  wire [17:0] a_i,
  output reg  [17:0] a_o,
  output reg  [17:0] a_oe_o,
  // B bus pins
  input  wire [17:0] b_i,
  output reg  [17:0] b_o,
  output reg  [17:0] b_oe_o,
  // per-half controls, index is the half
  input  wire [1:0]  fwd_output_enable_n_i,
  input  wire [1:0]  rev_output_enable_n_i,
  input  wire [1:0]  fwd_latch_enable_i,
  input  wire [1:0]  rev_latch_enable_i,
  input  wire [1:0]  fwd_store_clock_i,
  input  wire [1:0]  rev_store_clock_i,
  // serial test port
  input  wire        tck_i,
  input  wire        tms_i,
  input  wire        tdi_i,
  output reg         tdo_o,
  output reg         tdo_oe_o,
  // stored-word log stream
  output wire        log_valid_o,
  input  wire        log_ready_i,
  output wire [17:0] log_data_o,
  output wire        log_space_o
);
  // ========================================================================
  // tap states
  localparam [3:0] S_TLR = 4'h0, S_RTI = 4'h1, S_SDR = 4'h2, S_CDR = 4'h3;
  localparam [3:0] S_SHD = 4'h4, S_E1D = 4'h5, S_PSD = 4'h6, S_E2D = 4'h7;
  localparam [3:0] S_UDR = 4'h8, S_SIR = 4'h9, S_CIR = 4'hA, S_SHI = 4'hB;
  localparam [3:0] S_E1I = 4'hC, S_PSI = 4'hD, S_E2I = 4'hE, S_UIR = 4'hF;
  // pullup pins rest high, so the synchroniser does too
  localparam [50:0] SYNC_RST = {2'b11, 1'b0, 4'h0, 4'h0, 4'hF, 36'h0};
  function [7:0] sbt_decode;
    input [7:0] op;
    begin
      if (^op) begin
        sbt_decode = `SBT_OP_BYPASS;
      end else begin
        case (op)
          `SBT_OP_EXTEST, `SBT_OP_HIGHZ, `SBT_OP_RUNT, `SBT_OP_SCANCT,
          `SBT_OP_IDCODE, `SBT_OP_SAMPLE, `SBT_OP_CLAMP, `SBT_OP_SCANCN:
            sbt_decode = op;
          default: sbt_decode = `SBT_OP_BYPASS;
        endcase
      end
    end
  endfunction
  // ========================================================================
  // input synchronisers
  reg  [50:0] sync1;
  reg  [50:0] sync2;
  wire [50:0] raw = {tdi_i, tms_i, tck_i, rev_store_clock_i, fwd_store_clock_i,
                     rev_latch_enable_i, fwd_latch_enable_i,
                     rev_output_enable_n_i, fwd_output_enable_n_i, b_i, a_i};
  always @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sync1 <= SYNC_RST;
      sync2 <= SYNC_RST;
    end else begin
      sync1 <= raw;
      sync2 <= sync1;
    end
  end
  wire [17:0] a_s    = sync2[17:0];
  wire [17:0] b_s    = sync2[35:18];
  wire [1:0]  foe_n  = sync2[37:36];
  wire [1:0]  roe_n  = sync2[39:38];
  wire [1:0]  fle    = sync2[41:40];
  wire [1:0]  rle    = sync2[43:42];
  wire [1:0]  fclk   = sync2[45:44];
  wire [1:0]  rclk   = sync2[47:46];
  wire        tck_s  = sync2[48];
  wire        tms_s  = sync2[49];
  wire        tdi_s  = sync2[50];
  // boundary order of the control cells: per half oe_n f/r, le f/r, clk f/r
  wire [11:0] ctl_s  = {rclk[1], fclk[1], rle[1], fle[1], roe_n[1], foe_n[1],
                        rclk[0], fclk[0], rle[0], fle[0], roe_n[0], foe_n[0]};
  // ========================================================================
  // test clock edges
  reg         tck_d;
  reg  [1:0]  fclk_d;
  reg  [1:0]  rclk_d;
  wire        tck_rise = tck_s & ~tck_d;
  wire        tck_fall = ~tck_s & tck_d;
  always @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tck_d  <= 1'b0;
      fclk_d <= 2'h0;
      rclk_d <= 2'h0;
    end else begin
      tck_d  <= tck_s;
      fclk_d <= fclk;
      rclk_d <= rclk;
    end
  end
  // ========================================================================
  // instruction decode
  reg  [7:0]  ir;
  reg  [3:0]  tap;
  reg  [3:0]  next_tap;
  reg  [83:0] bs_upd;
  reg  [20:0] boundary_control_chain;
  wire [7:0]  op      = sbt_decode(ir);
  wire        op_highz = (op == `SBT_OP_HIGHZ);
  wire        op_runt  = (op == `SBT_OP_RUNT);
  wire        test_mode = (op == `SBT_OP_EXTEST) | op_highz | op_runt |
                          (op == `SBT_OP_CLAMP) | (op == `SBT_OP_SCANCT);
  wire        sel_bs  = (op == `SBT_OP_EXTEST) | (op == `SBT_OP_SAMPLE) | op_runt;
  wire        sel_bc  = (op == `SBT_OP_SCANCN) | (op == `SBT_OP_SCANCT);
  wire        sel_id  = (op == `SBT_OP_IDCODE);
  // ========================================================================
  // functional transceiver, two independent halves
  reg  [17:0] fwd_q;
  reg  [17:0] rev_q;
  reg  [17:0] next_fwd;
  reg  [17:0] next_rev;
  reg         fwd_clocked;
  integer     h;
  always @* begin
    next_fwd    = fwd_q;
    next_rev    = rev_q;
    fwd_clocked = 1'b0;
    for (h = 0; h < 2; h = h + 1) begin
      if (fle[h]) begin
        next_fwd[h*9 +: 9] = a_s[h*9 +: 9];
      end else if (fclk[h] & ~fclk_d[h]) begin
        next_fwd[h*9 +: 9] = a_s[h*9 +: 9];
        fwd_clocked        = 1'b1;
      end
      if (rle[h]) begin
        next_rev[h*9 +: 9] = b_s[h*9 +: 9];
      end else if (rclk[h] & ~rclk_d[h]) begin
        next_rev[h*9 +: 9] = b_s[h*9 +: 9];
      end
    end
  end
  // latch high falls through; steady clock with latch low holds
  always @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      fwd_q <= 18'h00000;
      rev_q <= 18'h00000;
    end else if (!test_mode) begin
      fwd_q <= next_fwd;
      rev_q <= next_rev;
    end
  end
  // ========================================================================
  // pin drivers
  wire [1:0] drv_b;
  wire [1:0] drv_a;
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_half
      assign drv_b[g] = test_mode ? (~op_highz & ~bs_upd[g*6])
                                  : ~foe_n[g];
      assign drv_a[g] = test_mode ? (~op_highz & ~bs_upd[g*6 + 1])
                                  : ~roe_n[g];
    end
  endgenerate
  always @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      a_o    <= 18'h00000;
      b_o    <= 18'h00000;
      a_oe_o <= 18'h00000;
      b_oe_o <= 18'h00000;
    end else begin
      b_o    <= test_mode ? bs_upd[`SBT_BS_BOUT +: 18] : next_fwd;
      a_o    <= test_mode ? bs_upd[`SBT_BS_AOUT +: 18] : next_rev;
      b_oe_o <= {{9{drv_b[1]}}, {9{drv_b[0]}}};
      a_oe_o <= {{9{drv_a[1]}}, {9{drv_a[0]}}};
    end
  end
  // ========================================================================
  // tap controller
  always @* begin
    case (tap)
      S_TLR:   next_tap = tms_s ? S_TLR : S_RTI;
      S_RTI:   next_tap = tms_s ? S_SDR : S_RTI;
      S_SDR:   next_tap = tms_s ? S_SIR : S_CDR;
      S_CDR:   next_tap = tms_s ? S_E1D : S_SHD;
      S_SHD:   next_tap = tms_s ? S_E1D : S_SHD;
      S_E1D:   next_tap = tms_s ? S_UDR : S_PSD;
      S_PSD:   next_tap = tms_s ? S_E2D : S_PSD;
      S_E2D:   next_tap = tms_s ? S_UDR : S_SHD;
      S_UDR:   next_tap = tms_s ? S_SDR : S_RTI;
      S_SIR:   next_tap = tms_s ? S_TLR : S_CIR;
      S_CIR:   next_tap = tms_s ? S_E1I : S_SHI;
      S_SHI:   next_tap = tms_s ? S_E1I : S_SHI;
      S_E1I:   next_tap = tms_s ? S_UIR : S_PSI;
      S_PSI:   next_tap = tms_s ? S_E2I : S_PSI;
      S_E2I:   next_tap = tms_s ? S_UIR : S_SHI;
      S_UIR:   next_tap = tms_s ? S_SDR : S_RTI;
      default: next_tap = S_TLR;
    endcase
  end
  // ========================================================================
  // test registers
  reg  [7:0]  ir_sh;
  reg  [83:0] bs_sh;
  reg  [20:0] bc_sh;
  reg  [31:0] id_sh;
  reg         byp;
  wire        side    = boundary_control_chain[`SBT_BC_SIDE];
  wire [1:0]  bc_op   = boundary_control_chain[`SBT_BC_OP +: 2];
  wire [17:0] mask    = boundary_control_chain[`SBT_BC_MASK +: 18];
  wire [17:0] obs_in  = side ? b_s : a_s;
  wire [17:0] sig     = side ? bs_upd[`SBT_BS_BIN +: 18] : bs_upd[`SBT_BS_AIN +: 18];
  wire [17:0] pat     = side ? bs_upd[`SBT_BS_AOUT +: 18] : bs_upd[`SBT_BS_BOUT +: 18];
  wire [17:0] sig_nx  = {sig[16:0], sig[17] ^ sig[10]} ^ (obs_in & mask);
  wire [17:0] pseudorandom_drive_nx = {pat[16:0], pat[17] ^ pat[10] ^ ~|pat[16:0]};
  wire [17:0] cnt_nx  = pat + 18'h00001;
  wire [83:0] bs_cap  = {b_o, b_s, a_o, a_s, ctl_s};
  wire        dr_lsb  = sel_bs ? bs_sh[0] : sel_bc ? bc_sh[0] : sel_id ? id_sh[0] : byp;
  reg  [17:0] next_sig;
  reg  [17:0] next_pat;
  always @* begin
    next_sig = sig;
    next_pat = pat;
    case (bc_op)
      `SBT_BCOP_PSA:   next_sig = sig_nx;
      `SBT_BCOP_PSEUDORANDOM_DRIVE:  next_pat = pseudorandom_drive_nx;
      `SBT_BCOP_COUNT: begin
        next_sig = sig_nx;
        next_pat = cnt_nx;
      end
      default: next_sig = sig;
    endcase
  end
  // every action keys off one test clock edge only
  always @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tap      <= S_TLR;
      ir       <= `SBT_OP_IDCODE;
      ir_sh    <= 8'h00;
      bs_sh    <= 84'h0;
      bs_upd   <= {72'h0, 12'hC3F};
      bc_sh    <= 21'h000000;
      boundary_control_chain      <= `SBT_BC_RESET;
      id_sh    <= 32'h00000000;
      byp      <= 1'b0;
      tdo_o    <= 1'b1;
      tdo_oe_o <= 1'b0;
    end else if (tck_rise) begin
      tap <= next_tap;
      case (tap)
        S_CIR: ir_sh <= `SBT_IR_STATUS;
        S_SHI: ir_sh <= {tdi_s, ir_sh[7:1]};
        S_CDR: begin
          bs_sh <= op_runt ? bs_upd : bs_cap;
          bc_sh <= boundary_control_chain;
          id_sh <= ID_CODE;
          byp   <= 1'b0;
        end
        S_SHD: begin
          if (sel_bs) begin
            bs_sh <= {tdi_s, bs_sh[83:1]};
          end else if (sel_bc) begin
            bc_sh <= {tdi_s, bc_sh[20:1]};
          end else if (sel_id) begin
            id_sh <= {tdi_s, id_sh[31:1]};
          end else begin
            byp <= tdi_s;
          end
        end
        S_RTI: begin
          if (op_runt && side) begin
            bs_upd[`SBT_BS_BIN +: 18]  <= next_sig;
            bs_upd[`SBT_BS_AOUT +: 18] <= next_pat;
          end else if (op_runt) begin
            bs_upd[`SBT_BS_AIN +: 18]  <= next_sig;
            bs_upd[`SBT_BS_BOUT +: 18] <= next_pat;
          end
        end
        default: byp <= byp;
      endcase
    end else if (tck_fall) begin
      tdo_o    <= (tap == S_SHI) ? ir_sh[0] : dr_lsb;
      tdo_oe_o <= (tap == S_SHI) | (tap == S_SHD);
      if (tap == S_TLR) begin
        ir  <= `SBT_OP_IDCODE;
        boundary_control_chain <= `SBT_BC_RESET;
      end else if (tap == S_UIR) begin
        ir <= ir_sh;
      end else if (tap == S_UDR && sel_bs) begin
        bs_upd <= bs_sh;
      end else if (tap == S_UDR && sel_bc) begin
        boundary_control_chain <= bc_sh;
      end
    end
  end
  // ========================================================================
  // log of clocked forward stores; a full buffer drops words, seen on log_space_o
  sbt_fifo #(.W(18), .D(LOG_DEPTH), .AW(3)) u_log (
    .ref_clk_i   (ref_clk_i),
    .resetn_i    (resetn_i),
    .in_valid_i  (fwd_clocked & ~test_mode),
    .in_ready_o  (log_space_o),
    .in_data_i   (next_fwd),
    .out_valid_o (log_valid_o),
    .out_ready_i (log_ready_i),
    .out_data_o  (log_data_o)
  );
endmodule // sbt_transceiver

// ### tb/sbt_tester.sv
`timescale 1ns/1ps
// ==========================================================================
// serial test master; test clock only runs inside frames
module sbt_tester (
  // clock
  input  wire  ref_clk_i,
  // test port
  output logic tck_o,
  output logic tms_o,
  output logic tdi_o,
  input  wire  tdo_i
);
  initial begin
    tck_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b1;
  end
  // 320 ns test clock; called at a rising edge; tdo read just before the rise
  task step(input logic m, input logic t, output logic q);
    tms_o <= m;
    tdi_o <= t;
    repeat (4) @(posedge ref_clk_i);
    q = tdo_i;
    tck_o <= 1'b1;
    repeat (4) @(posedge ref_clk_i);
    tck_o <= 1'b0;
  endtask
  task scan(input logic ir, input logic [83:0] din, input int n, output logic [83:0] dout);
    logic q;
    @(posedge ref_clk_i);
    step(1'b1, 1'b1, q);
    if (ir)
      step(1'b1, 1'b1, q);
    step(1'b0, 1'b1, q);
    step(1'b0, 1'b1, q);
    dout = '0;
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], q);
      dout[i] = q;
    end
    step(1'b1, 1'b1, q);
    step(1'b0, 1'b1, q); // released tdi rests at its pull-up level
  endtask
  task reset_tap;
    logic q;
    @(posedge ref_clk_i);
    repeat (5) step(1'b1, 1'b1, q);
    step(1'b0, 1'b1, q);
  endtask
endmodule // sbt_tester

// ### tb/sbt_transceiver_monitor.sv
`timescale 1ns/1ps
// ==========================================================================
// port checker
module sbt_transceiver_monitor (
  // clock and reset
  input wire        ref_clk_i,
  input wire        resetn_i,
  // bus pins
  input wire [17:0] a_i,
  input wire [17:0] a_o,
  input wire [17:0] a_oe_o,
  input wire [17:0] b_i,
  input wire [17:0] b_o,
  input wire [17:0] b_oe_o,
  // controls
  input wire [1:0]  fwd_output_enable_n_i,
  input wire [1:0]  rev_output_enable_n_i,
  input wire [1:0]  fwd_latch_enable_i,
  input wire [1:0]  rev_latch_enable_i,
  input wire [1:0]  fwd_store_clock_i,
  // test port
  input wire        tck_i,
  input wire        tms_i,
  input wire        tdo_o,
  input wire        tdo_oe_o,
  // log stream
  input wire        log_valid_o,
  input wire        log_ready_i,
  input wire [17:0] log_data_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);
  // path checks trusted from reset, and again once five tms-high rises prove normal mode,
  // and not before the pin synchronisers have refilled after reset
  reg  [1:0] tck_s;
  reg  [2:0] hi_n;
  reg  [2:0] age;
  wire       nm = (hi_n == 3'h5) && (age == 3'h7);
  always @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tck_s <= 2'h0;
      hi_n  <= 3'h5;
      age   <= 3'h0;
    end else begin
      age   <= (age == 3'h7) ? age : age + 3'h1;
      tck_s <= {tck_s[0], tck_i};
      if (tck_s == 2'h1)
        hi_n <= !tms_i ? 3'h0 : (nm ? 3'h5 : hi_n + 3'h1);
    end
  end
  fwd_pass_a: assert property (
    (nm && fwd_latch_enable_i[0] && $stable(a_i[8:0]))[*4] |-> b_o[8:0] == a_i[8:0])
    else $error("forward half 0 not transparent");
  upper_pass_a: assert property (
    (nm && fwd_latch_enable_i[1] && $stable(a_i[17:9]))[*4] |-> b_o[17:9] == a_i[17:9])
    else $error("forward half 1 not transparent");
  fwd_hold_a: assert property (
    (nm && !fwd_latch_enable_i[0] && $stable(fwd_store_clock_i[0]))[*5] |-> $stable(b_o[8:0]))
    else $error("latched value moved");
  fwd_store_a: assert property (
    (nm && !fwd_latch_enable_i[0] && $rose(fwd_store_clock_i[0]) && $stable(a_i[8:0]))
    ##1 (!fwd_latch_enable_i[0] && $stable(a_i[8:0]))[*2] |=> b_o[8:0] == $past(a_i[8:0]))
    else $error("clocked store missed");
  fwd_off_a: assert property (
    (nm && fwd_output_enable_n_i[0])[*4] |-> b_oe_o[8:0] == 9'h000)
    else $error("b driven while disabled");
  fwd_on_a: assert property (
    (nm && !fwd_output_enable_n_i[1])[*4] |-> b_oe_o[17:9] == 9'h1FF)
    else $error("b not driven while enabled");
  rev_pass_a: assert property (
    (nm && rev_latch_enable_i[1] && $stable(b_i[17:9]))[*4] |-> a_o[17:9] == b_i[17:9])
    else $error("reverse half 1 not transparent");
  rev_off_a: assert property (
    (nm && rev_output_enable_n_i[0])[*4] |-> a_oe_o[8:0] == 9'h000)
    else $error("a driven while disabled");
  tdo_edge_a: assert property (
    $changed({tdo_o, tdo_oe_o}) |-> !tck_i && !$past(tck_i, 2))
    else $error("serial output moved outside low test clock");
  tap_reset_a: assert property (nm |-> !tdo_oe_o)
    else $error("serial output active in reset state");
  log_hold_a: assert property (
    log_valid_o && !log_ready_i |=> log_valid_o && $stable(log_data_o))
    else $error("log word dropped while stalled");
  cover property (nm && fwd_latch_enable_i[0]);
  cover property (log_valid_o && log_ready_i);
  cover property ($rose(tdo_oe_o));
endmodule // sbt_transceiver_monitor

bind sbt_transceiver sbt_transceiver_monitor sbt_transceiver_monitor_i (.ref_clk_i, .resetn_i,
  .a_i, .a_o, .a_oe_o, .b_i, .b_o, .b_oe_o, .fwd_output_enable_n_i, .rev_output_enable_n_i,
  .fwd_latch_enable_i, .rev_latch_enable_i, .fwd_store_clock_i, .tck_i, .tms_i, .tdo_o,
  .tdo_oe_o, .log_valid_o, .log_ready_i, .log_data_o);

// ### tb/tb_sbt_transceiver.sv
`timescale 1ns/1ps
`include "sbt_regs.vh"
// ==========================================================================
// bench top
module tb_sbt_transceiver;
  localparam logic [31:0] ID = 32'h0000_3C4B; // arbitrary value
  logic        ref_clk_i = 1'b0;
  logic        resetn_i  = 1'b0;
  logic        log_ready_i = 1'b0;
  logic [17:0] a_i = 18'h0, b_i = 18'h0, a_o, a_oe_o, b_o, b_oe_o, log_data_o, v, x;
  logic [1:0]  foe = 2'h0, roe = 2'h3, fle = 2'h3, rle = 2'h0, fck = 2'h0, rck = 2'h0;
  logic        tck, tms, tdi, tdo_o, tdo_oe_o, log_valid_o, log_space_o;
  logic [83:0] d;
  logic [7:0]  ops[3] = '{`SBT_OP_INTEST, 8'h01, `SBT_OP_BYPASS};
  logic [17:0] exp_q[$];
  integer      seed = 38453, miscompares = 0, n_checks = 0;
  always #20 ref_clk_i = ~ref_clk_i;
  sbt_transceiver #(.ID_CODE(ID), .LOG_DEPTH(8)) sbt_transceiver_i (
    .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .a_i(a_i), .a_o(a_o), .a_oe_o(a_oe_o),
    .b_i(b_i), .b_o(b_o), .b_oe_o(b_oe_o), .fwd_output_enable_n_i(foe),
    .rev_output_enable_n_i(roe), .fwd_latch_enable_i(fle), .rev_latch_enable_i(rle),
    .fwd_store_clock_i(fck), .rev_store_clock_i(rck), .tck_i(tck), .tms_i(tms), .tdi_i(tdi),
    .tdo_o(tdo_o), .tdo_oe_o(tdo_oe_o), .log_valid_o(log_valid_o), .log_ready_i(log_ready_i),
    .log_data_o(log_data_o), .log_space_o(log_space_o));
  sbt_tester sbt_tester_i (.ref_clk_i(ref_clk_i), .tck_o(tck), .tms_o(tms), .tdi_o(tdi),
    .tdo_i(tdo_o));
  // ==========================================================================
  // helpers
  task cyc(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask
  task look;
    cyc(4);
    @(negedge ref_clk_i);
  endtask
  task chk(input logic [83:0] got, input logic [83:0] exp);
    n_checks = n_checks + 1;
    if (got !== exp) begin
      miscompares = miscompares + 1;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task results;
    if (miscompares == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task store(input logic [17:0] w);
    a_i <= w;
    cyc(2);
    fck <= 2'h3;
    cyc(3);
    fck <= 2'h0;
    cyc(3);
    @(negedge ref_clk_i);
    chk(b_o, w);
    cyc(1);
  endtask
  // log words are judged half a cycle ahead of the handshake edge
  always @(negedge ref_clk_i) begin
    if (log_valid_o === 1'b1 && log_ready_i === 1'b1) begin
      if (exp_q.size() == 0)
        chk(84'h1, 84'h0);
      else
        chk(log_data_o, exp_q.pop_front());
    end
  end
  initial begin
    cyc(50000);
    miscompares = miscompares + 1;
    results();
  end
  // ==========================================================================
  // scenarios
  initial begin
    cyc(2);
    resetn_i <= 1'b1;
    cyc(1);
    for (int k = 0; k < 4; k++) begin
      v = 18'($random(seed));
      a_i <= v;
      look();
      chk(b_o, v);
      chk(b_oe_o, 18'h3FFFF);
      cyc(1);
    end
    fle <= 2'h1;
    cyc(2);
    x = 18'($random(seed));
    v = {a_i[17:9], x[8:0]};
    a_i <= x;
    look();
    chk(b_o, v);
    cyc(1);
    fle <= 2'h0;
    cyc(2);
    // ninth store meets a full buffer and is dropped
    for (int k = 0; k < 9; k++) begin
      v = 18'($random(seed));
      if (k < 8)
        exp_q.push_back(v);
      store(v);
    end
    chk(log_space_o, 1'b0);
    repeat (40) begin
      log_ready_i <= 1'($random(seed));
      cyc(1);
    end
    log_ready_i <= 1'b1;
    cyc(12);
    chk(exp_q.size(), 0);
    foe <= 2'h1;
    roe <= 2'h0;
    rle <= 2'h3;
    v = 18'($random(seed));
    b_i <= v;
    look();
    chk(b_oe_o, {9'h1FF, 9'h000});
    chk({a_oe_o, a_o}, {18'h3FFFF, v});
    cyc(1);
    rle <= 2'h0;
    cyc(2);
    x = 18'($random(seed));
    b_i <= x;
    cyc(2);
    rck <= 2'h3;
    cyc(3);
    rck <= 2'h0;
    look();
    chk(a_o, x);
    cyc(1);
    fle <= 2'h3;
    foe <= 2'h0;
    sbt_tester_i.reset_tap();
    sbt_tester_i.scan(1'b0, 84'h0, 32, d);
    chk(d[31:0], ID);
    foreach (ops[i]) begin
      sbt_tester_i.scan(1'b1, {76'h0, ops[i]}, 8, d);
      chk(d[7:0], `SBT_IR_STATUS);
      sbt_tester_i.scan(1'b0, 84'h5, 4, d);
      chk(d[3:0], 4'hA);
    end
    sbt_tester_i.scan(1'b1, {76'h0, `SBT_OP_SAMPLE}, 8, d);
    sbt_tester_i.scan(1'b0, 84'h0, 84, d);
    chk({d[`SBT_BS_BIN +: 18], d[`SBT_BS_AIN +: 18]}, {b_i, a_i});
    look();
    chk(b_o, a_i);
    sbt_tester_i.scan(1'b1, {76'h0, `SBT_OP_HIGHZ}, 8, d);
    look();
    chk({a_oe_o, b_oe_o}, 36'h0);
    sbt_tester_i.reset_tap();
    look();
    chk(b_oe_o, 18'h3FFFF);
    results();
  end
endmodule // tb_sbt_transceiver
